// ### rtl/lpsi_core.v
// Control core of the ambient-light and proximity sensor with interrupt logic
//
// Overview of operation
// - Ambient and proximity conversions run on two independent concurrent converters.
// - Each ambient conversion takes nominally 100 ms and yields one result.
// - Each proximity reading switches the LED on in the same cycle that its conversion starts.
// - Each proximity conversion takes nominally 540 us.
// - LED pulse lasts 100 us per reading; sink amplitude selectable 110/220 mA.
// - Programmable sleep between proximity pulses, longest setting 800 ms.
// - Ambient range selectable 125 or 2000 lux; code proportional to light.
// - Ambient event when result lies outside the low/high threshold window.
// - Proximity event when result exceeds the proximity threshold.
// - Ambient and proximity thresholds are separate and independently programmable.
// - Interrupt after 1/4/8/16 consecutive triggers; a miss restarts the count.
// - Combined option: pin only when both conditions hold together, persistence applied.
// - Each event drives the interrupt pin and sets readable status bits; here the pin only follows events whose enable bit is set.
// - Interrupt pin is active-low open-drain: pulls low or releases.
// - Ambient results are 12-bit, proximity results 8-bit.
// - Cleared enable stops that channel; both cleared powers the sensor down.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "lpsi_defs.vh"
module lpsi_core #(
    parameter CW = 26,
    parameter [CW-1:0] AMB_CYC = `LPSI_AMB_CONV_CYC,
    parameter [CW-1:0] PROX_CYC = `LPSI_PROX_CONV_CYC,
    parameter [CW-1:0] SLEEP_CYC = `LPSI_SLEEP_STEP_CYC,
    parameter [6:0] ADDR_BASE = 7'h20
) (
    input wire I_CLK,
    input wire I_RST,
    input wire [3:0] I_ADDR,
    input wire [15:0] I_WDATA,
    input wire I_WE,
    input wire I_RE,
    output wire [15:0] O_RDATA,
    input wire I_SLAVE_ADDR_SELECT_PIN,
    output wire [6:0] O_SLAVE_ADDR,
    input wire [11:0] I_AMB_CODE,
    input wire [7:0] I_PROX_CODE,
    output wire O_AMB_ADC_ON,
    output wire O_AMB_RANGE,
    output wire O_PROX_ADC_ON,
    output wire O_LED_SINK_DRIVE,
    output wire O_LED_HIGH_CURRENT,
    output wire O_PWR_DOWN,
    input wire I_INT_N_I,
    output wire O_INT_N_O,
    output wire O_INT_N_OE
);

    localparam [CW-1:0] LED_CYC = `LPSI_LED_PULSE_CYC;
    localparam [1:0] P_IDLE = 2'h0;
    localparam [1:0] P_CONV = 2'h1;
    localparam [1:0] P_SLEEP = 2'h2;

    // Persistence code to number of consecutive triggers
    function [4:0] pers_need;
        input [1:0] code;
        begin
            case (code)
                2'h0: pers_need = 5'h01;
                2'h1: pers_need = 5'h04;
                2'h2: pers_need = 5'h08;
                default: pers_need = 5'h10;
            endcase
        end
    endfunction

    // Saturating consecutive-trigger counter; a miss returns it to zero
    function [4:0] pers_next;
        input [4:0] cnt;
        input cond;
        input [4:0] need;
        begin
            if (!cond) begin
                pers_next = 5'h00;
            end else if (cnt >= need) begin
                pers_next = need;
            end else begin
                pers_next = cnt + 5'h01;
            end
        end
    endfunction

    // Software-visible state
    reg [9:0] cfg_q;
    reg [11:0] amb_lo_q;
    reg [11:0] amb_hi_q;
    reg [7:0] prox_thr_q;
    reg [2:0] int_en_q;
    reg [2:0] int_st_q;
    reg [2:0] int_st_d;
    reg [15:0] rdata_q;
    reg [15:0] rdata_d;

    // Pin synchronisers
    reg [11:0] amb_s1_q;
    reg [11:0] amb_s2_q;
    reg [7:0] prox_s1_q;
    reg [7:0] prox_s2_q;
    reg asel_s1_q;
    reg asel_s2_q;
    reg intp_s1_q;
    reg intp_s2_q;

    // Proximity sequencing
    reg [1:0] pst_q;
    reg [1:0] pst_d;
    reg [CW-1:0] pcnt_q;
    reg [CW-1:0] pcnt_d;
    reg led_q;
    reg led_d;

    // Interrupt evaluation
    reg [4:0] amb_pc_q;
    reg [4:0] prox_pc_q;
    reg [4:0] both_pc_q;
    reg prox_cond_q;
    reg int_q;
    reg [6:0] slave_addr_q;

    wire amb_on;
    wire prox_on;
    wire combine;
    wire [4:0] need;
    wire [2:0] sleep_code;
    wire [CW-1:0] sleep_len;
    wire amb_busy;
    wire amb_done;
    wire [11:0] amb_res;
    wire prox_busy;
    wire prox_done;
    wire [7:0] prox_res;
    wire amb_cond;
    wire prox_cond;
    wire [4:0] amb_pc_n;
    wire [4:0] prox_pc_n;
    wire [4:0] both_pc_n;
    wire [2:0] ev;
    wire wr_clear;

    assign amb_on = cfg_q[`LPSI_CFG_AMB_ON];
    assign prox_on = cfg_q[`LPSI_CFG_PROX_ON];
    assign combine = cfg_q[`LPSI_CFG_COMBINE];
    assign need = pers_need(cfg_q[`LPSI_CFG_PERS_MSB:`LPSI_CFG_PERS_LSB]);
    assign sleep_code = cfg_q[`LPSI_CFG_SLEEP_MSB:`LPSI_CFG_SLEEP_LSB];
    // Sleep is one to eight steps
    assign sleep_len = SLEEP_CYC * ({{(CW-3){1'b0}}, sleep_code} + {{(CW-1){1'b0}}, 1'b1});

    // Two flops on the front-end code, address select and interrupt pins before use; front-end codes are held stable across conversion end
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            amb_s1_q <= 12'h000;
            amb_s2_q <= 12'h000;
            prox_s1_q <= 8'h00;
            prox_s2_q <= 8'h00;
            asel_s1_q <= 1'b0;
            asel_s2_q <= 1'b0;
            intp_s1_q <= 1'b1;
            intp_s2_q <= 1'b1;
        end else begin
            amb_s1_q <= I_AMB_CODE;
            amb_s2_q <= amb_s1_q;
            prox_s1_q <= I_PROX_CODE;
            prox_s2_q <= prox_s1_q;
            asel_s1_q <= I_SLAVE_ADDR_SELECT_PIN;
            asel_s2_q <= asel_s1_q;
            intp_s1_q <= I_INT_N_I;
            intp_s2_q <= intp_s1_q;
        end
    end

    // Address follows the tied select level
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            slave_addr_q <= 7'h00;
        end else begin
            slave_addr_q <= {ADDR_BASE[6:1], asel_s2_q};
        end
    end

    // One result per AMB_CYC conversion period
    lpsi_conv #(
        .W(12),
        .CW(CW)
    ) u_amb (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_start(amb_on && !amb_done),
        .i_abort(!amb_on),
        .i_len(AMB_CYC),
        .i_code(amb_s2_q),
        .o_busy(amb_busy),
        .o_done(amb_done),
        .o_result(amb_res)
    );

    // Proximity converter, 540 us, 8-bit result
    lpsi_conv #(
        .W(8),
        .CW(CW)
    ) u_prox (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_start(pst_q == P_IDLE && prox_on),
        .i_abort(!prox_on),
        .i_len(PROX_CYC),
        .i_code(prox_s2_q),
        .o_busy(prox_busy),
        .o_done(prox_done),
        .o_result(prox_res)
    );

    // Proximity sequence: LED on at start, convert, then sleep
    always @* begin
        pst_d = pst_q;
        pcnt_d = pcnt_q;
        led_d = 1'b0;
        case (pst_q)
            P_IDLE: begin
                pcnt_d = {CW{1'b0}};
                if (prox_on) begin
                    pst_d = P_CONV;
                    led_d = 1'b1;
                end
            end
            P_CONV: begin
                pcnt_d = pcnt_q + {{(CW-1){1'b0}}, 1'b1};
                led_d = (pcnt_d < LED_CYC);
                if (prox_done) begin
                    pst_d = P_SLEEP;
                    pcnt_d = {CW{1'b0}};
                    led_d = 1'b0;
                end
            end
            P_SLEEP: begin
                pcnt_d = pcnt_q + {{(CW-1){1'b0}}, 1'b1};
                if (pcnt_d >= sleep_len) begin
                    pst_d = P_IDLE;
                end
            end
            default: begin
                pst_d = P_IDLE;
            end
        endcase
        // Disabling the channel stops it at once
        if (!prox_on) begin
            pst_d = P_IDLE;
            led_d = 1'b0;
        end
    end

    // Proximity sequence registers
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            pst_q <= P_IDLE;
            pcnt_q <= {CW{1'b0}};
            led_q <= 1'b0;
        end else begin
            pst_q <= pst_d;
            pcnt_q <= pcnt_d;
            led_q <= led_d;
        end
    end

    assign amb_cond = (amb_res < amb_lo_q) || (amb_res > amb_hi_q);
    assign prox_cond = (prox_res > prox_thr_q);
    assign amb_pc_n = pers_next(amb_pc_q, amb_cond, need);
    assign prox_pc_n = pers_next(prox_pc_q, prox_cond, need);
    // Combined condition, judged at each ambient result against the latest proximity
    assign both_pc_n = pers_next(both_pc_q, amb_cond && prox_cond_q, need);
    assign ev[`LPSI_INT_AMB] = amb_done && !combine && (amb_pc_n == need);
    assign ev[`LPSI_INT_PROX] = prox_done && !combine && (prox_pc_n == need);
    assign ev[`LPSI_INT_BOTH] = amb_done && combine && (both_pc_n == need);

    // Counters advance only when a result arrives
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            amb_pc_q <= 5'h00;
            prox_pc_q <= 5'h00;
            both_pc_q <= 5'h00;
            prox_cond_q <= 1'b0;
        end else begin
            if (amb_done) begin
                amb_pc_q <= amb_pc_n;
                both_pc_q <= both_pc_n;
            end
            if (prox_done) begin
                prox_pc_q <= prox_pc_n;
                prox_cond_q <= prox_cond;
            end
            // Stale evidence is dropped when a channel stops
            if (!amb_on) begin
                amb_pc_q <= 5'h00;
                both_pc_q <= 5'h00;
            end
            if (!prox_on) begin
                prox_pc_q <= 5'h00;
                prox_cond_q <= 1'b0;
            end
        end
    end

    assign wr_clear = I_WE && (I_ADDR == `LPSI_REG_INT_CLEAR);

    // Sticky status; a new event wins over a clear in the same cycle
    always @* begin
        int_st_d = int_st_q;
        if (wr_clear) begin
            int_st_d = int_st_q & ~I_WDATA[2:0];
        end
        int_st_d = int_st_d | ev;
    end

    // Status and pin registers
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            int_st_q <= 3'h0;
            int_q <= 1'b0;
        end else begin
            int_st_q <= int_st_d;
            int_q <= |(int_st_d & int_en_q);
        end
    end

    // Separate threshold sets, plus configuration writes
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            cfg_q <= `LPSI_RST_CONFIG;
            amb_lo_q <= `LPSI_RST_AMB_LO;
            amb_hi_q <= `LPSI_RST_AMB_HI;
            prox_thr_q <= `LPSI_RST_PROX_THR;
            int_en_q <= `LPSI_RST_INT_ENABLE;
        end else if (I_WE) begin
            case (I_ADDR)
                `LPSI_REG_CONFIG: cfg_q <= I_WDATA[9:0];
                `LPSI_REG_AMB_LO: amb_lo_q <= I_WDATA[11:0];
                `LPSI_REG_AMB_HI: amb_hi_q <= I_WDATA[11:0];
                `LPSI_REG_PROX_THR: prox_thr_q <= I_WDATA[7:0];
                `LPSI_REG_INT_ENABLE: int_en_q <= I_WDATA[2:0];
                default: begin
                end
            endcase
        end
    end

    // Read mux; data stand for one cycle only, unmapped and write-only offsets read zero
    always @* begin
        rdata_d = 16'h0000;
        if (I_RE) begin
            case (I_ADDR)
                `LPSI_REG_CONFIG: rdata_d = {6'h00, cfg_q};
                `LPSI_REG_AMB_LO: rdata_d = {4'h0, amb_lo_q};
                `LPSI_REG_AMB_HI: rdata_d = {4'h0, amb_hi_q};
                `LPSI_REG_PROX_THR: rdata_d = {8'h00, prox_thr_q};
                `LPSI_REG_AMB_DATA: rdata_d = {4'h0, amb_res};
                `LPSI_REG_PROX_DATA: rdata_d = {8'h00, prox_res};
                `LPSI_REG_INT_STATUS: rdata_d = {12'h000, !intp_s2_q, int_st_q};
                `LPSI_REG_INT_ENABLE: rdata_d = {13'h0000, int_en_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Read data register
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs to the host and the analog side
    assign O_RDATA = rdata_q;
    assign O_SLAVE_ADDR = slave_addr_q;
    // Range select steers front-end gain; the code stays proportional
    assign O_AMB_RANGE = cfg_q[`LPSI_CFG_AMB_RANGE];
    assign O_AMB_ADC_ON = amb_busy;
    assign O_PROX_ADC_ON = prox_busy;
    assign O_LED_SINK_DRIVE = led_q;
    // Amplitude select, high means 220 mA
    assign O_LED_HIGH_CURRENT = cfg_q[`LPSI_CFG_LED_HIGH];
    // Both channels off powers the sensor down
    assign O_PWR_DOWN = !amb_on && !prox_on;
    // Open drain: only ever drives low
    assign O_INT_N_O = 1'b0;
    assign O_INT_N_OE = int_q;

endmodule

// ### rtl/lpsi_defs.vh
// Register offsets, field positions, reset values and timing constants of the sensor core
`ifndef LPSI_DEFS_VH
`define LPSI_DEFS_VH

// Register offsets
`define LPSI_REG_CONFIG 4'h0
`define LPSI_REG_AMB_LO 4'h1
`define LPSI_REG_AMB_HI 4'h2
`define LPSI_REG_PROX_THR 4'h3
`define LPSI_REG_AMB_DATA 4'h4
`define LPSI_REG_PROX_DATA 4'h5
`define LPSI_REG_INT_STATUS 4'h6
`define LPSI_REG_INT_CLEAR 4'h7
`define LPSI_REG_INT_ENABLE 4'h8

// Configuration field positions
`define LPSI_CFG_AMB_ON 0
`define LPSI_CFG_PROX_ON 1
`define LPSI_CFG_AMB_RANGE 2
`define LPSI_CFG_LED_HIGH 3
`define LPSI_CFG_SLEEP_LSB 4
`define LPSI_CFG_SLEEP_MSB 6
`define LPSI_CFG_PERS_LSB 7
`define LPSI_CFG_PERS_MSB 8
`define LPSI_CFG_COMBINE 9

// Interrupt status field positions
`define LPSI_INT_AMB 0
`define LPSI_INT_PROX 1
`define LPSI_INT_BOTH 2
`define LPSI_INT_PIN 3

// Reset values
`define LPSI_RST_CONFIG 10'h000
`define LPSI_RST_AMB_LO 12'h000
`define LPSI_RST_AMB_HI 12'hFFF
`define LPSI_RST_PROX_THR 8'hFF
`define LPSI_RST_INT_ENABLE 3'h0

// Times in their own units
`define LPSI_CLK_MHZ 40
`define LPSI_AMB_CONV_MS 100
`define LPSI_PROX_CONV_US 540
`define LPSI_LED_PULSE_US 100
`define LPSI_SLEEP_STEP_MS 100

// Derived cycle counts
`define LPSI_AMB_CONV_CYC (`LPSI_AMB_CONV_MS * 1000 * `LPSI_CLK_MHZ)
`define LPSI_PROX_CONV_CYC (`LPSI_PROX_CONV_US * `LPSI_CLK_MHZ)
`define LPSI_LED_PULSE_CYC (`LPSI_LED_PULSE_US * `LPSI_CLK_MHZ)
`define LPSI_SLEEP_STEP_CYC (`LPSI_SLEEP_STEP_MS * 1000 * `LPSI_CLK_MHZ)

`endif

// ### rtl/lpsi_conv.v
// One conversion timer: runs for a given length and captures the front-end code at its end
`timescale 1ns/1ps
module lpsi_conv #(
    parameter W = 12,
    parameter CW = 26
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_start,
    input wire i_abort,
    input wire [CW-1:0] i_len,
    input wire [W-1:0] i_code,
    output wire o_busy,
    output wire o_done,
    output wire [W-1:0] o_result
);

    reg busy_q;
    reg busy_d;
    reg done_q;
    reg done_d;
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] cnt_d;
    reg [W-1:0] result_q;
    reg [W-1:0] result_d;

    // Next state; the result only moves when a conversion finishes
    always @* begin
        busy_d = busy_q;
        done_d = 1'b0;
        cnt_d = cnt_q;
        result_d = result_q;
        if (busy_q) begin
            if (i_abort) begin
                busy_d = 1'b0;
            end else if (cnt_q == i_len - {{(CW-1){1'b0}}, 1'b1}) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                result_d = i_code;
            end else begin
                cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1};
            end
        end else if (i_start && !i_abort) begin
            busy_d = 1'b1;
            cnt_d = {CW{1'b0}};
        end
    end

    // State registers
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
            result_q <= {W{1'b0}};
        end else begin
            busy_q <= busy_d;
            done_q <= done_d;
            cnt_q <= cnt_d;
            result_q <= result_d;
        end
    end

    assign o_busy = busy_q;
    assign o_done = done_q;
    assign o_result = result_q;

endmodule

// ### tb/lpsi_checker.sv
// Concurrent checks on the sensor core pins, bound to every core instance
`timescale 1ns/1ps
module lpsi_checker #(
    parameter int PROX_CYC = 20,
    parameter logic [6:0] ADDR_BASE = 7'h20
) (
    input wire I_CLK,
    input wire I_RST,
    input wire I_WE,
    input wire I_RE,
    input wire [15:0] O_RDATA,
    input wire I_SLAVE_ADDR_SELECT_PIN,
    input wire [6:0] O_SLAVE_ADDR,
    input wire O_AMB_ADC_ON,
    input wire O_PROX_ADC_ON,
    input wire O_LED_SINK_DRIVE,
    input wire O_PWR_DOWN,
    input wire O_INT_N_O,
    input wire O_INT_N_OE
);
    // One spare cycle allowed for the start handshake inside the converter
    localparam int PROX_N = PROX_CYC + 1;
    int prox_run_q;
    // Length of the running proximity conversion
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST)
            prox_run_q <= 0;
        else if (O_PROX_ADC_ON)
            prox_run_q <= prox_run_q + 1;
        else
            prox_run_q <= 0;
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    a_rdata_after_read: assert property (!$past(I_RE) |-> O_RDATA == 16'h0000)
        else $error("read data outside its cycle");
    a_od_drive_low: assert property (O_INT_N_O == 1'b0)
        else $error("interrupt pin driven high");
    a_int_host_clear: assert property ($fell(O_INT_N_OE) |-> $past(I_WE) || $past(I_WE, 2) || $past(I_WE, 3))
        else $error("interrupt released without a host write");
    a_pwr_down_idle: assert property (O_PWR_DOWN [*3] |-> !O_AMB_ADC_ON && !O_PROX_ADC_ON && !O_LED_SINK_DRIVE)
        else $error("activity while powered down");
    a_prox_conv_len: assert property (prox_run_q <= PROX_N)
        else $error("proximity conversion too long");
    a_led_with_conv: assert property ($rose(O_PROX_ADC_ON) |-> ##[0:1] O_LED_SINK_DRIVE)
        else $error("proximity conversion without LED");
    a_led_pulse_end: assert property ($fell(O_PROX_ADC_ON) |-> ##[0:1] !O_LED_SINK_DRIVE)
        else $error("LED left on after conversion");
    a_prox_sleep_gap: assert property ($fell(O_PROX_ADC_ON) |-> !O_PROX_ADC_ON [*8])
        else $error("proximity restarted without sleep");
    a_addr_strap_hi: assert property (I_SLAVE_ADDR_SELECT_PIN [*4] |=> O_SLAVE_ADDR == {ADDR_BASE[6:1], 1'b1})
        else $error("slave address wrong for strap high");
    a_addr_strap_lo: assert property (!I_SLAVE_ADDR_SELECT_PIN [*4] |=> O_SLAVE_ADDR == {ADDR_BASE[6:1], 1'b0})
        else $error("slave address wrong for strap low");
    c_int_raised: cover property ($rose(O_INT_N_OE));
    c_prox_done: cover property ($fell(O_PROX_ADC_ON));
    c_amb_start: cover property ($rose(O_AMB_ADC_ON));
endmodule

bind lpsi_core lpsi_checker #(.PROX_CYC(PROX_CYC), .ADDR_BASE(ADDR_BASE)) u_chk (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_WE(I_WE), .I_RE(I_RE), .O_RDATA(O_RDATA),
    .I_SLAVE_ADDR_SELECT_PIN(I_SLAVE_ADDR_SELECT_PIN), .O_SLAVE_ADDR(O_SLAVE_ADDR),
    .O_AMB_ADC_ON(O_AMB_ADC_ON), .O_PROX_ADC_ON(O_PROX_ADC_ON), .O_LED_SINK_DRIVE(O_LED_SINK_DRIVE),
    .O_PWR_DOWN(O_PWR_DOWN), .O_INT_N_O(O_INT_N_O), .O_INT_N_OE(O_INT_N_OE)
);

// ### tb/lpsi_int_line.sv
// Board side of the interrupt line: pull-up resolving the core's open-drain drive
`timescale 1ns/1ps
module lpsi_int_line (
    input wire logic i_oe,
    input wire logic i_o,
    output wire logic o_wire
);
    assign o_wire = i_oe ? i_o : 1'b1; // Pull-up wins whenever nobody sinks
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the sensor core: register tasks, conversions and interrupts
`timescale 1ns/1ps
`include "lpsi_defs.vh"
module tb_top;
    // Short counts keep the run brief; the persistence waits are fixed counts sized for these, proximity conversion and sleep are timed by bounded level waits
    localparam int AMB = 50;
    localparam int PRX = 20;
    localparam int SLP = 10;
    localparam logic [3:0] RA [10] = '{`LPSI_REG_CONFIG, `LPSI_REG_AMB_LO, `LPSI_REG_AMB_HI, `LPSI_REG_PROX_THR,
        `LPSI_REG_INT_ENABLE, `LPSI_REG_AMB_DATA, `LPSI_REG_PROX_DATA, `LPSI_REG_INT_STATUS,
        `LPSI_REG_INT_CLEAR, 4'hF};
    localparam logic [15:0] RV [10] = '{16'h0000, 16'h0000, 16'h0FFF, 16'h00FF, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000};
    logic I_CLK = 1'b0;
    logic I_RST = 1'b1;
    logic [3:0] I_ADDR = 4'h0;
    logic [15:0] I_WDATA = 16'h0000;
    logic I_WE = 1'b0;
    logic I_RE = 1'b0;
    logic strap = 1'b1;
    logic [11:0] amb_code = 12'h200;
    logic [7:0] prox_code = 8'h80;
    wire [15:0] rdata;
    wire [6:0] slave_addr;
    wire amb_on, amb_rng, prox_on, led, led_hi, pwr_dn, int_o, int_oe, int_n;
    int error_cnt = 0;
    int total_checks = 0;
    int n;
    lpsi_core #(.AMB_CYC(AMB), .PROX_CYC(PRX), .SLEEP_CYC(SLP), .ADDR_BASE(7'h2A)) uut (
        .I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WE(I_WE), .I_RE(I_RE),
        .O_RDATA(rdata), .I_SLAVE_ADDR_SELECT_PIN(strap), .O_SLAVE_ADDR(slave_addr), .I_AMB_CODE(amb_code),
        .I_PROX_CODE(prox_code), .O_AMB_ADC_ON(amb_on), .O_AMB_RANGE(amb_rng), .O_PROX_ADC_ON(prox_on),
        .O_LED_SINK_DRIVE(led), .O_LED_HIGH_CURRENT(led_hi), .O_PWR_DOWN(pwr_dn), .I_INT_N_I(int_n),
        .O_INT_N_O(int_o), .O_INT_N_OE(int_oe)
    );
    lpsi_int_line u_line (.i_oe(int_oe), .i_o(int_o), .o_wire(int_n));
    // Free-running core clock
    initial begin
        forever #12.5 I_CLK = ~I_CLK;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge I_CLK);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        total_checks++;
        if (g < lo || g > hi) begin
            error_cnt++;
            $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
        end
    endtask
    // One-cycle write strobe, dropped at the edge that takes it
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WE <= 1'b1;
        @(posedge I_CLK);
        I_WE <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_RE <= 1'b1;
        @(posedge I_CLK);
        I_RE <= 1'b0;
        #1;
        chk($sformatf("reg %0h", a), e, rdata);
    endtask
    task automatic set_amb(input int k, input logic [11:0] c);
        tick(k);
        @(posedge I_CLK);
        amb_code <= c;
    endtask
    // Bounded wait for a proximity busy level, counting cycles
    task automatic wait_prox(input logic lvl, output int k);
        k = 0;
        while (prox_on !== lvl && k < 1000) begin
            tick(1);
            k++;
        end
        // A wait that runs out is a failure, not a silent pass
        if (k >= 1000) begin
            error_cnt++;
            $display("BAD prox wait exp level %0b got timeout", lvl);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog well past the expected run of about 1400 cycles
    initial begin
        repeat (20000) @(posedge I_CLK);
        error_cnt++;
        $display("BAD watchdog exp finish got hang");
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge I_CLK);
        I_RST <= 1'b0;
        tick(6);
        chk("addr strap high", 16'h002B, {9'h000, slave_addr});
        chk("power down", 16'h0001, {15'h0000, pwr_dn});
        wr(`LPSI_REG_AMB_DATA, 16'h0ABC);
        foreach (RA[i]) rd(RA[i], RV[i]);
        @(posedge I_CLK);
        strap <= 1'b0;
        tick(6);
        chk("addr strap low", 16'h002A, {9'h000, slave_addr});
        wr(`LPSI_REG_AMB_LO, 16'h0100);
        wr(`LPSI_REG_AMB_HI, 16'hF200);
        wr(`LPSI_REG_PROX_THR, 16'h0080);
        rd(`LPSI_REG_AMB_HI, 16'h0200);
        rd(`LPSI_REG_PROX_THR, 16'h0080);
        wr(`LPSI_REG_CONFIG, 16'h000C);
        tick(2);
        chk("range led pdn", 16'h0007, {13'h0000, amb_rng, led_hi, pwr_dn});
        $display("test registers done");
        wr(`LPSI_REG_INT_ENABLE, 16'h0007);
        wr(`LPSI_REG_CONFIG, 16'h0001);
        tick(AMB - 10);
        rd(`LPSI_REG_AMB_DATA, 16'h0000);
        tick(20);
        rd(`LPSI_REG_AMB_DATA, 16'h0200);
        chk("prox idle", 16'h0000, {15'h0000, prox_on});
        rd(`LPSI_REG_INT_STATUS, 16'h0000);
        set_amb(0, 12'h201);
        tick(2 * AMB + 10);
        rd(`LPSI_REG_INT_STATUS, 16'h0009);
        chk("pin low", 16'h0000, {15'h0000, int_n});
        set_amb(0, 12'h150);
        tick(2 * AMB + 10);
        chk("pin held", 16'h0000, {15'h0000, int_n});
        wr(`LPSI_REG_INT_CLEAR, 16'h0001);
        tick(3);
        rd(`LPSI_REG_INT_STATUS, 16'h0000);
        chk("pin freed", 16'h0001, {15'h0000, int_n});
        wr(`LPSI_REG_CONFIG, 16'h0000);
        $display("test ambient window done");
        set_amb(10, 12'h0FF);
        wr(`LPSI_REG_CONFIG, 16'h0081);
        set_amb(128, 12'h100);
        set_amb(50, 12'h0FF);
        tick(156);
        rd(`LPSI_REG_INT_STATUS, 16'h0000);
        tick(48);
        rd(`LPSI_REG_INT_STATUS, 16'h0009);
        wr(`LPSI_REG_CONFIG, 16'h0000);
        wr(`LPSI_REG_INT_CLEAR, 16'h0007);
        $display("test persistence done");
        wr(`LPSI_REG_CONFIG, 16'h0072);
        wait_prox(1'b1, n);
        wait_prox(1'b0, n);
        chk_rng("prox conv", PRX, PRX + 1, n);
        wait_prox(1'b1, n);
        chk_rng("prox sleep", 8 * SLP, 8 * SLP + 4, n);
        rd(`LPSI_REG_PROX_DATA, 16'h0080);
        rd(`LPSI_REG_INT_STATUS, 16'h0000);
        @(posedge I_CLK);
        prox_code <= 8'h81;
        tick(230);
        rd(`LPSI_REG_PROX_DATA, 16'h0081);
        rd(`LPSI_REG_INT_STATUS, 16'h000A);
        wr(`LPSI_REG_CONFIG, 16'h0000);
        wr(`LPSI_REG_INT_CLEAR, 16'h0002);
        $display("test proximity done");
        set_amb(10, 12'h0FF);
        prox_code <= 8'h10;
        wr(`LPSI_REG_CONFIG, 16'h0203);
        tick(2 * AMB + 20);
        rd(`LPSI_REG_INT_STATUS, 16'h0000);
        @(posedge I_CLK);
        prox_code <= 8'h90;
        tick(2 * AMB + 20);
        rd(`LPSI_REG_INT_STATUS, 16'h000C);
        wr(`LPSI_REG_CONFIG, 16'h0000);
        wr(`LPSI_REG_INT_CLEAR, 16'h0007);
        tick(4);
        rd(`LPSI_REG_INT_STATUS, 16'h0000);
        chk("power down again", 16'h0001, {15'h0000, pwr_dn});
        $display("test combined done");
        report_and_stop();
    end
endmodule
